// ### shared/dsenv_pkg.sv
// Shared constants and types for the delay-and-sum envelope detector
package dsenv_pkg;

	// Default geometry of the datapath
	localparam int DSENV_CHANNELS  = 8;  // Transducer channels summed
	localparam int DSENV_SAMPLE_W  = 14; // Converter sample width
	localparam int DSENV_DELAY_W   = 5;  // Integer delay code width, in samples
	localparam int DSENV_FRAC_W    = 2;  // Fractional delay code width, quarter period steps
	localparam int DSENV_DEC_M     = 4;  // Decimation factor

	// Pipeline depth in clock cycles from an accepted sample to each result
	localparam int DSENV_MEM_LAT   = 1;  // History read
	localparam int DSENV_FRAC_LAT  = 1;  // Interpolation
	localparam int DSENV_SUM_LAT   = 1;  // Channel sum
	localparam int DSENV_MIX_LAT   = 1;  // Quadrature mix
	localparam int DSENV_DEC_LAT   = 1;  // Filter dump
	localparam int DSENV_LAT_IQ    = DSENV_MEM_LAT + DSENV_FRAC_LAT + DSENV_SUM_LAT
		+ DSENV_MIX_LAT + DSENV_DEC_LAT;
	localparam int DSENV_LAT_ENV   = DSENV_LAT_IQ + 1;

	// Values after reset
	localparam logic [1:0] DSENV_PHASE_RST = 2'h0; // Carrier phase at start of a run

	// Acquisition control states
	typedef enum logic {
		DSENV_IDLE,
		DSENV_RUN
	} dsenv_state_type;

endpackage

// ### shared/dsenv_mem_if.sv
// Port bundle between the datapath and one channel's sample history memory
`timescale 1ns/100ps
interface dsenv_mem_if #(
	parameter int WIDTH  = 14,
	parameter int ADDR_W = 6
);
	logic              wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [WIDTH-1:0]  wr_data;
	logic [ADDR_W-1:0] rd_addr_a;
	logic [ADDR_W-1:0] rd_addr_b;
	logic [WIDTH-1:0]  rd_data_a;
	logic [WIDTH-1:0]  rd_data_b;

	modport user (output wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b,
		input rd_data_a, rd_data_b);
	modport mem (input wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b,
		output rd_data_a, rd_data_b);
endinterface

// ### logic/dsenv_delay_mem.sv
// Circular sample history for one channel with two registered read ports
`timescale 1ns/100ps
module dsenv_delay_mem import dsenv_pkg::*; #(
	parameter int WIDTH  = DSENV_SAMPLE_W,
	parameter int ADDR_W = DSENV_DELAY_W + 1
) (
	input wire logic   ref_clk_i, // System clock
	dsenv_mem_if.mem   port       // Write and read ports
);

	logic [WIDTH-1:0] ram [2**ADDR_W];

	// Store the newest sample
	always_ff @(posedge ref_clk_i) begin
		if (port.wr_en) begin
			ram[port.wr_addr] <= port.wr_data;
		end
	end

	// Read both taps; a tap on the slot being written sees the new sample
	always_ff @(posedge ref_clk_i) begin
		port.rd_data_a <= (port.wr_en && port.rd_addr_a == port.wr_addr) ? port.wr_data
			: ram[port.rd_addr_a];
		port.rd_data_b <= (port.wr_en && port.rd_addr_b == port.wr_addr) ? port.wr_data
			: ram[port.rd_addr_b];
	end

endmodule

// ### logic/dsenv_top.sv
// Delay-and-sum beamformer with quadrature envelope detector and decimator
// Operation
// - Each channel's delay has an integer part that is a whole number of sample periods.
// - What is left of the delay after the integer part is a fraction of one sample period.
// - The integer delay is taken first by reading the stored sample that many accepted samples back.
// - The integer index is the floor of delay over sample period, the nearest newer sample.
// - The fraction is applied after the integer stage by interpolating between neighbours.
// - All fully delayed channels are added and the sum feeds the envelope stage.
// - The envelope stage demodulates first and decimates second.
// - In-phase is the carrier cosine coefficient, quadrature the carrier sine coefficient.
// - The envelope magnitude is the square root of in-phase squared plus quadrature squared.
// - Both demodulated streams are low-pass filtered with cutoff pi over M before decimation.
// - After filtering one sample in every M is kept on each stream.
// - Decimated in-phase and quadrature streams are delivered for the next stage.
`timescale 1ns/100ps
module dsenv_top import dsenv_pkg::*; #(
	parameter int CH      = DSENV_CHANNELS,
	parameter int SAMP_W  = DSENV_SAMPLE_W,
	parameter int DEL_W   = DSENV_DELAY_W,
	parameter int FRAC_W  = DSENV_FRAC_W,
	parameter int DEC_M   = DSENV_DEC_M,
	parameter int SUM_W   = SAMP_W + 1 + $clog2(CH),
	parameter int OUT_W   = SUM_W + 1 + $clog2(2 * DEC_M),
	parameter int ENV_W   = OUT_W + 1
) (
	input  wire logic                       ref_clk_i,    // 50 MHz system clock
	input  wire logic                       reset_i,      // Synchronous reset, active high
	input  wire logic                       acq_run_i,    // High while an acquisition runs
	input  wire logic                       adc_valid_i,  // One converter sample per channel
	input  wire logic [CH*SAMP_W-1:0]       adc_data_i,   // Signed samples, channel 0 low
	input  wire logic [CH*DEL_W-1:0]        int_delay_i,  // Whole-sample delay per channel
	input  wire logic [CH*FRAC_W-1:0]       frac_delay_i, // Fraction code per channel
	output logic                            busy_o,       // Run in progress, codes frozen
	output logic signed [OUT_W-1:0]         i_dec_o,      // Decimated in-phase
	output logic signed [OUT_W-1:0]         q_dec_o,      // Decimated quadrature
	output logic                            iq_valid_o,   // Pulse with each I/Q pair
	output logic [ENV_W-1:0]                env_o,        // Envelope magnitude
	output logic                            env_valid_o   // Pulse with each magnitude
);

	localparam int AW    = DEL_W + 1;          // History depth twice the longest delay
	localparam int MIX_W = SUM_W + 1;
	localparam int CW    = $clog2(2 * DEC_M);
	localparam int SQ_W  = 2 * ENV_W;
	localparam logic [CW-1:0] CNT_LAST = CW'(2 * DEC_M - 1);

	// Refuse shapes the datapath cannot serve
	initial begin
		if (CH < 1 || SAMP_W < 2 || DEL_W < 1 || FRAC_W < 1 || DEC_M < 2) begin
			$error("dsenv_top: unsupported parameter values");
		end
		if (OUT_W < SUM_W + 1 + $clog2(2 * DEC_M) || ENV_W <= OUT_W) begin
			$error("dsenv_top: output widths too narrow");
		end
	end

	// Integer square root, one result bit per step from the top
	function automatic logic [ENV_W-1:0] isqrt(input logic [SQ_W-1:0] v);
		logic [ENV_W-1:0] r;
		logic [ENV_W-1:0] t;
		r = '0;
		for (int b = ENV_W - 1; b >= 0; b--) begin
			t = r | (ENV_W'(1) << b);
			if (SQ_W'(t) * SQ_W'(t) <= v) begin
				r = t;
			end
		end
		return r;
	endfunction

	dsenv_state_type        state_q;
	logic [CH*DEL_W-1:0]    int_del_q;
	logic [CH*FRAC_W-1:0]   frac_del_q;
	logic                   take;
	logic [AW-1:0]          wptr_q;
	logic [AW:0]            fill_q;
	logic                   v1_q, v2_q, v3_q, v4_q;
	logic signed [SAMP_W:0] interp_q [CH];
	logic signed [SUM_W-1:0] sum_d, sum_q;
	logic [1:0]             phase_q;
	logic signed [MIX_W-1:0] mix_i_q, mix_q_q;
	logic [CW-1:0]          cnt_q;
	logic                   primed_q;
	logic signed [OUT_W-1:0] acc_q [2][2];
	logic signed [SQ_W-1:0] iw, qw;
	logic [SQ_W-1:0]        msq;

	// Run control: codes track the inputs while idle and freeze during a run
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_q <= DSENV_IDLE;
		end else begin
			case (state_q)
				DSENV_IDLE: if (acq_run_i) state_q <= DSENV_RUN;
				DSENV_RUN:  if (!acq_run_i) state_q <= DSENV_IDLE;
				default:    state_q <= DSENV_IDLE;
			endcase
		end
	end

	// Capture delay codes only outside a run
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			int_del_q  <= '0;
			frac_del_q <= '0;
		end else if (state_q == DSENV_IDLE) begin
			int_del_q  <= int_delay_i;
			frac_del_q <= frac_delay_i;
		end
	end

	assign take = adc_valid_i && state_q == DSENV_RUN;

	// Write pointer and saturating fill count advance once per accepted sample
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			wptr_q <= '0;
			fill_q <= '0;
		end else if (take) begin
			wptr_q <= wptr_q + AW'(1);
			if (!fill_q[AW]) begin
				fill_q <= fill_q + (AW+1)'(1);
			end
		end
	end

	// Per-channel history, integer tap and fractional interpolation
	for (genvar c = 0; c < CH; c++) begin : g_chan
		dsenv_mem_if #(.WIDTH(SAMP_W), .ADDR_W(AW)) mif ();
		logic [DEL_W-1:0]              dly;
		logic [FRAC_W-1:0]             frc;
		logic signed [SAMP_W-1:0]      tap_a, tap_b;
		logic                          ok_a_q, ok_b_q;
		logic signed [SAMP_W:0]        diff;
		logic signed [SAMP_W+FRAC_W+1:0] prod;
		logic signed [SAMP_W+FRAC_W+1:0] mixed;

		assign dly              = int_del_q[c*DEL_W +: DEL_W];
		assign frc              = frac_del_q[c*FRAC_W +: FRAC_W];
		assign mif.wr_en        = take;
		assign mif.wr_addr      = wptr_q;
		assign mif.wr_data      = adc_data_i[c*SAMP_W +: SAMP_W];
		assign mif.rd_addr_a    = wptr_q - AW'(dly);
		assign mif.rd_addr_b    = wptr_q - AW'(dly) - AW'(1);

		dsenv_delay_mem #(.WIDTH(SAMP_W), .ADDR_W(AW)) u_mem (
			.ref_clk_i (ref_clk_i),
			.port      (mif.mem)
		);

		// Unwritten slots since reset read zero; step toward the older tap by frc/2^FRAC_W
		assign tap_a = ok_a_q ? mif.rd_data_a : '0;
		assign tap_b = ok_b_q ? mif.rd_data_b : '0;
		assign diff  = $signed({tap_b[SAMP_W-1], tap_b})
			- $signed({tap_a[SAMP_W-1], tap_a});
		assign prod  = diff * $signed({1'b0, frc});
		assign mixed = (SAMP_W + FRAC_W + 2)'(tap_a) + (prod >>> FRAC_W);

		always_ff @(posedge ref_clk_i) begin
			ok_a_q      <= ((AW+1)'(dly) <= fill_q);
			ok_b_q      <= ((AW+1)'(dly) + (AW+1)'(1) <= fill_q);
			interp_q[c] <= mixed[SAMP_W:0];
		end
	end

	// Add the aligned channels
	always_comb begin
		sum_d = '0;
		for (int c = 0; c < CH; c++) begin
			sum_d = sum_d + SUM_W'(interp_q[c]);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		sum_q <= sum_d;
	end

	// Stage valid chain; cleared whenever no run is active
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || state_q != DSENV_RUN) begin
			v1_q <= 1'b0;
			v2_q <= 1'b0;
			v3_q <= 1'b0;
			v4_q <= 1'b0;
		end else begin
			v1_q <= take;
			v2_q <= v1_q;
			v3_q <= v2_q;
			v4_q <= v3_q;
		end
	end

	// Quadrature mix at a quarter of the sample rate: cos 1,0,-1,0 and sin 0,1,0,-1
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || state_q != DSENV_RUN) begin
			phase_q <= DSENV_PHASE_RST;
			mix_i_q <= '0;
			mix_q_q <= '0;
		end else if (v3_q) begin
			phase_q <= phase_q + 2'h1;
			case (phase_q)
				2'h0: begin
					mix_i_q <= MIX_W'(sum_q);
					mix_q_q <= '0;
				end
				2'h1: begin
					mix_i_q <= '0;
					mix_q_q <= MIX_W'(sum_q);
				end
				2'h2: begin
					mix_i_q <= -MIX_W'(sum_q);
					mix_q_q <= '0;
				end
				default: begin
					mix_i_q <= '0;
					mix_q_q <= -MIX_W'(sum_q);
				end
			endcase
		end
	end

	// Position within the 2M-sample filter window
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || state_q != DSENV_RUN) begin
			cnt_q    <= '0;
			primed_q <= 1'b0;
		end else if (v4_q) begin
			cnt_q <= (cnt_q == CNT_LAST) ? '0 : cnt_q + CW'(1);
			if (cnt_q == CW'(DEC_M)) begin
				primed_q <= 1'b1;
			end
		end
	end

	// Two boxcars of 2M samples staggered by M: null at pi/M, one dump every M
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || state_q != DSENV_RUN) begin
			for (int k = 0; k < 2; k++) begin
				acc_q[k][0] <= '0;
				acc_q[k][1] <= '0;
			end
			iq_valid_o <= 1'b0;
			if (reset_i) begin // Last pair holds after a run ends
				i_dec_o <= '0;
				q_dec_o <= '0;
			end
		end else begin
			iq_valid_o <= 1'b0;
			if (v4_q) begin
				for (int k = 0; k < 2; k++) begin
					if (cnt_q == CW'(k * DEC_M)) begin
						acc_q[k][0] <= OUT_W'(mix_i_q);
						acc_q[k][1] <= OUT_W'(mix_q_q);
					end else begin
						acc_q[k][0] <= acc_q[k][0] + OUT_W'(mix_i_q);
						acc_q[k][1] <= acc_q[k][1] + OUT_W'(mix_q_q);
					end
					if (cnt_q == CW'((k * DEC_M + 2 * DEC_M - 1) % (2 * DEC_M))
						&& (k == 0 || primed_q)) begin
						i_dec_o    <= acc_q[k][0] + OUT_W'(mix_i_q);
						q_dec_o    <= acc_q[k][1] + OUT_W'(mix_q_q);
						iq_valid_o <= 1'b1;
					end
				end
			end
		end
	end

	// Squared magnitude of the decimated pair
	always_comb begin
		iw  = SQ_W'(i_dec_o);
		qw  = SQ_W'(q_dec_o);
		msq = $unsigned(iw * iw + qw * qw);
	end

	// Envelope one cycle after each I/Q pair
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			env_o       <= '0;
			env_valid_o <= 1'b0;
		end else begin
			env_valid_o <= iq_valid_o;
			if (iq_valid_o) begin
				env_o <= isqrt(msq);
			end
		end
	end

	// Busy flag mirrors the run state
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			busy_o <= 1'b0;
		end else begin
			busy_o <= acq_run_i;
		end
	end

endmodule

// ### dv/dsenv_adc_model.sv
// Converter sample source feeding all channels of the beamformer
`timescale 1ns/100ps
module dsenv_adc_model import dsenv_pkg::*; #(
	parameter int CH     = DSENV_CHANNELS,
	parameter int SAMP_W = DSENV_SAMPLE_W
) (
	input  wire logic             ref_clk_i, // System clock
	input  wire logic             stall_i,   // Leave random gaps between samples
	output logic                  valid_o,   // Sample present on all channels
	output logic [CH*SAMP_W-1:0]  data_o     // Signed samples, channel 0 low
);
	int          seed = 84989;
	logic [31:0] rnd;

	// New full-scale sample per channel; between samples the lines show garbage
	always @(posedge ref_clk_i) begin
		rnd = $random(seed);
		valid_o <= stall_i ? rnd[31] : 1'b1;
		for (int c = 0; c < CH; c++) begin
			rnd = $random(seed);
			data_o[c*SAMP_W +: SAMP_W] <= rnd[SAMP_W-1:0];
		end
	end
endmodule

// ### dv/dsenv_top_chk.sv
// Port-level timing checks for the delay-and-sum envelope detector
`timescale 1ns/100ps
module dsenv_top_chk #(
	parameter int OUT_W = 22,
	parameter int ENV_W = 23
) (
	input wire logic                    ref_clk_i,
	input wire logic                    reset_i,
	input wire logic                    acq_run_i,
	input wire logic                    adc_valid_i,
	input wire logic                    busy_o,
	input wire logic signed [OUT_W-1:0] i_dec_o,
	input wire logic signed [OUT_W-1:0] q_dec_o,
	input wire logic                    iq_valid_o,
	input wire logic [ENV_W-1:0]        env_o,
	input wire logic                    env_valid_o
);
	logic [2:0] cnt_q;
	logic       full_q;
	logic       emit;
	longint     mag_q;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	// Accepted samples in the current run; emit marks a window end
	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !busy_o) begin
			cnt_q  <= 3'h0;
			full_q <= 1'b0;
		end else if (adc_valid_i) begin
			cnt_q <= cnt_q + 3'h1;
			if (cnt_q == 3'h7)
				full_q <= 1'b1;
		end
	end
	assign emit = busy_o && adc_valid_i && cnt_q[1:0] == 2'h3 && (cnt_q == 3'h7 || full_q);

	// Squared magnitude of the pair on show
	always_ff @(posedge ref_clk_i) begin
		mag_q <= longint'(i_dec_o) * longint'(i_dec_o) + longint'(q_dec_o) * longint'(q_dec_o);
	end

	busy_follow_a: assert property (busy_o == $past(acq_run_i))
		else $error("busy does not follow run request");
	iq_timing_a: assert property (emit ##1 busy_o [*5] |-> iq_valid_o)
		else $error("missing output pulse after window end");
	iq_cause_a: assert property (iq_valid_o |-> $past(emit, 5))
		else $error("output pulse without a completed window");
	env_follow_a: assert property (iq_valid_o |=> env_valid_o)
		else $error("magnitude pulse missing after pair");
	env_cause_a: assert property (env_valid_o |-> $past(iq_valid_o))
		else $error("magnitude pulse without a pair");
	env_hold_a: assert property (!env_valid_o |-> $stable(env_o))
		else $error("magnitude changed between pulses");
	iq_hold_a: assert property (!iq_valid_o |-> $stable(i_dec_o) && $stable(q_dec_o))
		else $error("pair changed between pulses");
	env_value_a: assert property (env_valid_o |-> longint'(env_o) * longint'(env_o) <= mag_q
		&& (longint'(env_o) + 1) * (longint'(env_o) + 1) > mag_q)
		else $error("magnitude is not the root of the sum of squares");

	cover property (iq_valid_o && i_dec_o != 0);
	cover property (env_valid_o && env_o != 0);
	cover property (busy_o ##1 !busy_o);
endmodule

bind dsenv_top dsenv_top_chk #(.OUT_W(OUT_W), .ENV_W(ENV_W)) u_dsenv_top_chk (
	.ref_clk_i(ref_clk_i), .reset_i(reset_i), .acq_run_i(acq_run_i),
	.adc_valid_i(adc_valid_i), .busy_o(busy_o), .i_dec_o(i_dec_o), .q_dec_o(q_dec_o),
	.iq_valid_o(iq_valid_o), .env_o(env_o), .env_valid_o(env_valid_o));

// ### dv/dsenv_top_test.sv
// Self-checking bench: random runs of the beamformer against a sample-level model
`timescale 1ns/100ps
module dsenv_top_test import dsenv_pkg::*;;
	localparam int CH = DSENV_CHANNELS;
	localparam int SW = DSENV_SAMPLE_W;
	localparam int OW = SW + 1 + $clog2(CH) + 1 + $clog2(2 * DSENV_DEC_M);

	logic                 ref_clk_i = 1'b0;
	logic                 reset_i, acq_run_i, stall, adc_valid_i;
	logic [CH*SW-1:0]     adc_data_i;
	logic [CH*5-1:0]      int_delay_i;
	logic [CH*2-1:0]      frac_delay_i;
	logic                 busy_o, iq_valid_o, env_valid_o, run_q, env_chk;
	logic signed [OW-1:0] i_dec_o, q_dec_o;
	logic [OW:0]          env_o;
	logic [63:0]          rnd;
	int                   seed = 84989;
	int                   mismatches = 0;
	int                   total_checks = 0;
	int                   dl[CH], fr[CH], xs[CH][$], sq[$];
	longint               ei[$], eq[$], env_exp;
	bit                   eok[$];

	dsenv_top u_dsenv_top (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .acq_run_i(acq_run_i),
		.adc_valid_i(adc_valid_i), .adc_data_i(adc_data_i), .int_delay_i(int_delay_i),
		.frac_delay_i(frac_delay_i), .busy_o(busy_o), .i_dec_o(i_dec_o), .q_dec_o(q_dec_o),
		.iq_valid_o(iq_valid_o), .env_o(env_o), .env_valid_o(env_valid_o));
	dsenv_adc_model u_dsenv_adc_model (.ref_clk_i(ref_clk_i), .stall_i(stall),
		.valid_o(adc_valid_i), .data_o(adc_data_i));

	always #10 ref_clk_i = ~ref_clk_i;

	// Compare one design value with its expectation
	task automatic check(input logic signed [63:0] seen, input logic signed [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %0d expected %0d", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	function automatic longint isqrt(longint v);
		longint r = 0;
		for (int b = 24; b >= 0; b--)
			if ((r + (64'sd1 << b)) * (r + (64'sd1 << b)) <= v)
				r += 64'sd1 << b;
		return r;
	endfunction

	// Record a taken sample; at each window end queue the expected pair
	task automatic take();
		int k, a, b, s;
		longint i, q;
		k = xs[0].size();
		s = 0;
		for (int c = 0; c < CH; c++)
			xs[c].push_back($signed(adc_data_i[c*SW +: SW]));
		for (int c = 0; c < CH && k >= 40; c++) begin
			a = xs[c][k-dl[c]];
			b = xs[c][k-dl[c]-1];
			s += a + (((b - a) * fr[c]) >>> 2);
		end
		sq.push_back(s);
		if (k >= 7 && k % 4 == 3) begin
			i = 0;
			q = 0;
			for (int j = k - 7; j <= k; j++) begin
				i += (j % 4 == 0) ? sq[j] : (j % 4 == 2) ? -sq[j] : 0;
				q += (j % 4 == 1) ? sq[j] : (j % 4 == 3) ? -sq[j] : 0;
			end
			ei.push_back(i);
			eq.push_back(q);
			eok.push_back(k >= 47);
		end
	endtask

	// Monitor: sample inputs and outputs as they stood before the edge
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			run_q = 1'b0;
			env_chk = 1'b0;
		end else begin
			if (env_valid_o && env_chk)
				check(env_o, env_exp);
			env_chk = 1'b0;
			if (!run_q && acq_run_i) begin
				foreach (xs[c]) xs[c].delete();
				sq.delete(); ei.delete(); eq.delete(); eok.delete();
			end
			if (run_q && adc_valid_i)
				take();
			if (iq_valid_o) begin
				if (ei.size() == 0)
					check(1, 0);
				else if (eok.pop_front()) begin
					check(i_dec_o, ei[0]);
					check(q_dec_o, eq[0]);
					env_exp = isqrt(ei[0] * ei[0] + eq[0] * eq[0]);
					env_chk = 1'b1;
				end
				void'(ei.pop_front());
				void'(eq.pop_front());
			end
			run_q = acq_run_i;
		end
	end

	initial begin
		#40000;
		mismatches++;
		finish_test();
	end

	// Runs with corner then random codes, codes scrambled mid-run, last run cut mid-window
	initial begin
		reset_i = 1'b1;
		acq_run_i = 1'b0;
		stall = 1'b0;
		int_delay_i = '0;
		frac_delay_i = '0;
		repeat (2) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		for (int r = 0; r < 4; r++) begin
			for (int c = 0; c < CH; c++) begin
				dl[c] = r == 0 ? (c == 0 ? 0 : c == CH - 1 ? 31 : c * 4) : {$random(seed)} % 32;
				fr[c] = r == 0 ? c % 4 : {$random(seed)} % 4;
				int_delay_i[c*5 +: 5] <= 5'(dl[c]);
				frac_delay_i[c*2 +: 2] <= 2'(fr[c]);
			end
			stall <= r[0];
			repeat (3) @(posedge ref_clk_i);
			acq_run_i <= 1'b1;
			repeat (3) @(posedge ref_clk_i);
			repeat (150 + r) begin
				@(posedge ref_clk_i);
				rnd = {$random(seed), $random(seed)};
				int_delay_i <= rnd[39:0];
				frac_delay_i <= rnd[55:40];
			end
			acq_run_i <= 1'b0;
			repeat (10) @(posedge ref_clk_i);
		end
		finish_test();
	end
endmodule
